/* File: bench/nvsc_dev_model.sv */
/*
 behavioural 8k x 8 nonvolatile sram with store/recall sequence.
 assumes pins registered on clk_sys by the host.
*/
`timescale 1ns/100ps
module nvsc_dev_model
(
  input wire logic clk_sys,
  input wire logic [12:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic [7:0] mem_dq_o,
  output logic [7:0] mem_dq_i,
  output int stores = 0,
  output int recalls = 0
);
  logic [7:0] sram [0:8191];
  logic [7:0] nvm [0:8191];
  logic [12:0] seq [0:4] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff,
    13'h10f0};
  int idx = 0;
  int bsy = 0;
  logic ce_q = 1'b1;
  logic wr = 1'b0;
  logic six = 1'b0;
  logic up = 1'b0;
  logic [7:0] last = 8'h00;
  always @(posedge clk_sys)
  begin
    ce_q <= mem_ce_n;
    last <= mem_dq_i;
    // power-up recall: sram and nvm both load the low address byte
    if (!up)
    begin
      up <= 1'b1;
      for (int k = 0; k < 8192; k++)
      begin
        nvm[k] <= 8'(k);
        sram[k] <= 8'(k);
      end
    end
    // busy runs on, ce and all pins ignored
    else if (bsy > 0)
      bsy <= bsy - 1;
    // a ce fall counts, oe and data unused
    else if (ce_q && !mem_ce_n)
    begin
      wr <= !mem_we_n;
      six <= 1'b0;
      // write or stray cycle breaks sequence
      if (!mem_we_n)
        idx <= 0;
      else if (idx == 5 && mem_addr[12:1] == 12'h787)
      begin
        six <= 1'b1;
        idx <= 0;
        bsy <= 16;
        // supply held good, so no store inhibit
        if (mem_addr[0])
        begin
          stores <= stores + 1;
          for (int k = 0; k < 8192; k++)
            nvm[k] <= sram[k];
        end
        else
        begin
          recalls <= recalls + 1;
          for (int k = 0; k < 8192; k++)
            sram[k] <= nvm[k];
        end
      end
      else if (idx < 5 && mem_addr == seq[idx])
        idx <= idx + 1;
      else
        idx <= (mem_addr == 13'h0000) ? 1 : 0;
    end
    // write lands at end of select
    else if (!ce_q && mem_ce_n && wr)
      sram[mem_addr] <= mem_dq_o;
  end
  always @*
    if (!mem_ce_n && mem_we_n && !mem_oe_n && !wr && !six)
      mem_dq_i = sram[mem_addr];
    else
      mem_dq_i = ~last;
endmodule // nvsc_dev_model

/* File: bench/nvsc_host_properties.sv */
/*
 pin-side checks for the nonvolatile sram host controller.
 assumes binding onto nvsc_host, one clock domain.
*/
`timescale 1ns/100ps
module nvsc_host_properties
#(
  parameter int unsigned STORE_CYCLES = 20
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic nv_busy,
  input wire logic [12:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic mem_dq_oe
);
  int unsigned busy_r;
  int unsigned busy_nxt;
  always_comb busy_nxt = nv_busy ? busy_r + 1 : 0;
  always_ff @(posedge clk_sys) busy_r <= srst ? 0 : busy_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_read_we_high:
    assert property ($fell(mem_ce_n) && !mem_oe_n |-> mem_we_n)
      else $error("read started with write strobe low");
  a_seq_we_held:
    assert property (!mem_ce_n && mem_we_n |=> mem_we_n || mem_ce_n)
      else $error("write strobe fell inside a read");
  a_write_drives:
    assert property (!mem_we_n |-> !mem_ce_n && mem_dq_oe)
      else $error("write strobe without select or data");
  a_no_fight:
    assert property (!mem_oe_n |-> !mem_dq_oe)
      else $error("host drives data while output enabled");
  a_busy_quiet:
    assert property (nv_busy |-> mem_ce_n && !req_ready)
      else $error("access during nonvolatile wait");
  a_busy_bound:
    assert property (busy_r <= STORE_CYCLES + 32)
      else $error("nonvolatile wait too long");
  a_seq_busy:
    assert property ($fell(mem_ce_n) && mem_oe_n && mem_we_n &&
      mem_addr[12:1] == 12'h787 |-> ##[1:20] nv_busy)
      else $error("sixth sequence read not followed by wait");
  a_read_len:
    assert property ($fell(mem_ce_n) && !mem_oe_n |->
      ##[6:9] (rsp_valid && mem_ce_n))
      else $error("read answer missing");
  a_power_wait:
    assert property ($fell(srst) |-> nv_busy [*8])
      else $error("no power-up recall wait");
  c_seq: cover property ($fell(mem_ce_n) && mem_addr == 13'h0f0f);
  c_write: cover property ($fell(mem_we_n));
  c_read: cover property ($fell(mem_ce_n) && !mem_oe_n);
  c_recall: cover property ($fell(mem_ce_n) && mem_addr == 13'h0f0e);
endmodule // nvsc_host_properties

/* File: bench/nvsc_host_test.sv */
/*
 self-checking bench for nvsc_host against the device model.
 assumes shortened wait parameters of 20 cycles.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module nvsc_host_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  nvsc_pkg::nvsc_op_t req_op = nvsc_pkg::NVSC_OP_READ;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, nv_busy, mem_ce_n, mem_we_n, mem_oe_n;
  logic mem_dq_oe, busy_seen;
  logic [7:0] rsp_rdata, mem_dq_i, mem_dq_o;
  logic [12:0] mem_addr;
  int stores, recalls, err_total = 0, checks_done = 0, cyc = 0;
  nvsc_host #(.STORE_CYCLES(20), .RECALL_CYCLES(20),
    .POWERUP_CYCLES(20)) i_nvsc_host (.*);
  nvsc_dev_model i_nvsc_dev_model (.*);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic issue(input nvsc_pkg::nvsc_op_t op,
    input logic [12:0] a, input logic [7:0] d);
    int n;
    busy_seen = 1'b0;
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    `CHK("ready", 1'b1, req_ready)
    @(posedge clk_sys);
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++)
    begin
      @(negedge clk_sys);
      if (nv_busy === 1'b1)
        busy_seen = 1'b1;
    end
    `CHK("answer", 1'b1, rsp_valid)
  endtask
  task automatic t_power;
    int n;
    @(negedge clk_sys);
    `CHK("power-up busy", 1'b1, nv_busy)
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    `CHK("ready after wait", 1'b1, req_ready)
    issue(nvsc_pkg::NVSC_OP_READ, 13'h0042, 8'h00);
    `CHK("power-up data", 8'h42, rsp_rdata)
    $display("test power done");
  endtask
  task automatic t_wr_rd;
    logic [12:0] a [0:2] = '{13'h0000, 13'h1555, 13'h1fff};
    logic [7:0] d [0:2] = '{8'ha5, 8'h5a, 8'hc3};
    for (int i = 0; i < 3; i++) issue(nvsc_pkg::NVSC_OP_WRITE, a[i], d[i]);
    for (int i = 0; i < 3; i++)
    begin
      issue(nvsc_pkg::NVSC_OP_READ, a[i], 8'h00);
      `CHK("read back", d[i], rsp_rdata)
    end
    `CHK("no stray store", 0, stores)
    $display("test write read done");
  endtask
  task automatic t_nv;
    issue(nvsc_pkg::NVSC_OP_WRITE, 13'h0100, 8'h3c);
    issue(nvsc_pkg::NVSC_OP_STORE, 13'h0000, 8'h00);
    `CHK("store count", 1, stores)
    `CHK("store wait", 1'b1, busy_seen)
    issue(nvsc_pkg::NVSC_OP_WRITE, 13'h0100, 8'h00);
    issue(nvsc_pkg::NVSC_OP_RECALL, 13'h0000, 8'h00);
    `CHK("recall count", 1, recalls)
    `CHK("recall wait", 1'b1, busy_seen)
    `CHK("store unchanged", 1, stores)
    issue(nvsc_pkg::NVSC_OP_READ, 13'h0100, 8'h00);
    `CHK("recalled data", 8'h3c, rsp_rdata)
    $display("test store recall done");
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_power();
    t_wr_rd();
    t_nv();
    end_sim();
  end
endmodule // nvsc_host_test
bind nvsc_host nvsc_host_properties #(.STORE_CYCLES(STORE_CYCLES))
  i_nvsc_host_properties (.*);

/* File: hw/nvsc_host.sv */
/*
 host controller driving an 8k x 8 nonvolatile sram over its pins.
 assumes a single-beat request port and pins synchronous to clk_sys.
*/
// Summary of operation
// - a store is six back-to-back reads of 0000,1555,0aaa,1fff,10f0,0f0f.
// - a recall uses the same first five reads and 0f0e as the sixth.
// - the write strobe stays high during all six sequence reads.
// - every read keeps the write strobe high for the whole access.
`timescale 1ns/100ps
module nvsc_host
#(
  parameter int unsigned STORE_CYCLES = nvsc_pkg::STORE_CYC,
  parameter int unsigned RECALL_CYCLES = nvsc_pkg::RECALL_CYC,
  parameter int unsigned POWERUP_CYCLES = nvsc_pkg::RECALL_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nvsc_pkg::nvsc_op_t req_op,
  input wire logic [12:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic nv_busy,
  output logic [12:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  input wire logic [7:0] mem_dq_i,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe
);
  typedef enum logic [2:0] {
    NVSC_ST_IDLE = 3'b000,
    NVSC_ST_RD = 3'b001,
    NVSC_ST_WR = 3'b010,
    NVSC_ST_GAP = 3'b011,
    NVSC_ST_NVWAIT = 3'b100,
    NVSC_ST_SEQSET = 3'b101
  } nvsc_state_t;

  nvsc_state_t state_r, state_nxt;
  logic [24:0] cnt_r, cnt_nxt;
  logic [2:0] step_r, step_nxt;
  logic seq_r, seq_nxt;
  logic recall_r, recall_nxt;
  logic [12:0] addr_r, addr_nxt;
  logic ce_n_r, ce_n_nxt;
  logic we_n_r, we_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [12:0] seq_addr;

  nvsc_seq_rom i_nvsc_seq_rom
  (
    .clk_sys(clk_sys),
    .idx(step_nxt),
    .is_recall(recall_nxt),
    .addr(seq_addr)
  );

  assign req_ready = (state_r == NVSC_ST_IDLE);
  assign nv_busy = (state_r == NVSC_ST_NVWAIT);
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rdata_r;
  assign mem_addr = addr_r;
  assign mem_ce_n = ce_n_r;
  assign mem_we_n = we_n_r;
  assign mem_oe_n = oe_n_r;
  assign mem_dq_o = wdata_r;
  assign mem_dq_oe = dq_oe_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    seq_nxt = seq_r;
    recall_nxt = recall_r;
    addr_nxt = addr_r;
    ce_n_nxt = ce_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    wdata_nxt = wdata_r;
    dq_oe_nxt = dq_oe_r;
    rsp_valid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    unique case (state_r)
      NVSC_ST_IDLE:
      begin
        if (req_valid)
        begin
          unique case (req_op)
            nvsc_pkg::NVSC_OP_READ:
            begin
              addr_nxt = req_addr;
              we_n_nxt = 1'b1;
              ce_n_nxt = 1'b0;
              oe_n_nxt = 1'b0;
              cnt_nxt = 25'(nvsc_pkg::ACC_CYC);
              state_nxt = NVSC_ST_RD;
            end
            nvsc_pkg::NVSC_OP_WRITE:
            begin
              // write with ce and we low
              // we falls with ce; oe held high keeps device outputs off
              addr_nxt = req_addr;
              wdata_nxt = req_wdata;
              dq_oe_nxt = 1'b1;
              oe_n_nxt = 1'b1;
              we_n_nxt = 1'b0;
              ce_n_nxt = 1'b0;
              cnt_nxt = 25'(nvsc_pkg::WR_CYC);
              state_nxt = NVSC_ST_WR;
            end
            nvsc_pkg::NVSC_OP_STORE, nvsc_pkg::NVSC_OP_RECALL:
            begin
              seq_nxt = 1'b1;
              recall_nxt = (req_op == nvsc_pkg::NVSC_OP_RECALL);
              step_nxt = 3'h0;
              state_nxt = NVSC_ST_SEQSET;
            end
          endcase
        end
      end
      NVSC_ST_SEQSET:
      begin
        // sixth address picks store or recall
        addr_nxt = seq_addr;
        // write strobe held high in the sequence
        we_n_nxt = 1'b1;
        // oe kept high, sequence needs no output
        oe_n_nxt = 1'b1;
        ce_n_nxt = 1'b0;
        cnt_nxt = 25'(nvsc_pkg::ACC_CYC);
        state_nxt = NVSC_ST_RD;
      end
      NVSC_ST_RD:
      begin
        if (cnt_r > 25'h1)
        begin
          cnt_nxt = cnt_r - 25'h1;
        end
        else
        begin
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (!seq_r)
          begin
            rdata_nxt = mem_dq_i;
            rsp_valid_nxt = 1'b1;
          end
          cnt_nxt = 25'(nvsc_pkg::REC_CYC);
          state_nxt = NVSC_ST_GAP;
        end
      end
      NVSC_ST_WR:
      begin
        if (cnt_r > 25'h1)
        begin
          cnt_nxt = cnt_r - 25'h1;
        end
        else
        begin
          ce_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          rsp_valid_nxt = 1'b1;
          cnt_nxt = 25'(nvsc_pkg::REC_CYC);
          state_nxt = NVSC_ST_GAP;
        end
      end
      NVSC_ST_GAP:
      begin
        dq_oe_nxt = 1'b0;
        if (cnt_r > 25'h1)
        begin
          cnt_nxt = cnt_r - 25'h1;
        end
        else if (seq_r && step_r != nvsc_pkg::SEQ_LEN - 3'h1)
        begin
          // exactly one ce cycle per step
          step_nxt = step_r + 3'h1;
          state_nxt = NVSC_ST_SEQSET;
        end
        else if (seq_r)
        begin
          seq_nxt = 1'b0;
          cnt_nxt = recall_r ? 25'(RECALL_CYCLES) : 25'(STORE_CYCLES);
          state_nxt = NVSC_ST_NVWAIT;
        end
        else
        begin
          state_nxt = NVSC_ST_IDLE;
        end
      end
      NVSC_ST_NVWAIT:
      begin
        if (cnt_r > 25'h1)
        begin
          cnt_nxt = cnt_r - 25'h1;
        end
        else
        begin
          rsp_valid_nxt = 1'b1;
          state_nxt = NVSC_ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = NVSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      // device recalls on power-up, wait it out
      state_r <= NVSC_ST_NVWAIT;
      cnt_r <= 25'(POWERUP_CYCLES);
      step_r <= 3'h0;
      seq_r <= 1'b0;
      recall_r <= 1'b0;
      addr_r <= 13'h0000;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      wdata_r <= 8'h00;
      dq_oe_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      seq_r <= seq_nxt;
      recall_r <= recall_nxt;
      addr_r <= addr_nxt;
      ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      wdata_r <= wdata_nxt;
      dq_oe_r <= dq_oe_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule // nvsc_host

/* File: hw/nvsc_pkg.sv */
/*
 constants for the host-side controller of an 8k x 8 nonvolatile sram.
 assumes a 125 mhz system clock; pin timing is expressed in clk_sys cycles.
*/
package nvsc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_NS = 8;
  // access and write pulse figures, ns
  localparam int unsigned T_ACCESS_NS = 55;
  localparam int unsigned T_WRPULSE_NS = 45;
  localparam int unsigned T_RECOVER_NS = 25;
  // nonvolatile busy times
  localparam int unsigned T_STORE_MS = 12;
  localparam int unsigned T_RECALL_US = 25;
  // least times round up to whole cycles, access gets one cycle more
  localparam int unsigned ACC_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned WR_CYC = (T_WRPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REC_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STORE_CYC = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned RECALL_CYC = T_RECALL_US * CLK_MHZ;
  localparam int unsigned AW = 13;
  localparam int unsigned DW = 8;
  // nonvolatile sequence addresses
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0aaa;
  localparam logic [12:0] SEQ_A3 = 13'h1fff;
  localparam logic [12:0] SEQ_A4 = 13'h10f0;
  localparam logic [12:0] SEQ_STORE = 13'h0f0f;
  localparam logic [12:0] SEQ_RECALL = 13'h0f0e;
  localparam logic [2:0] SEQ_LEN = 3'h6;
  typedef enum logic [1:0] {
    NVSC_OP_READ = 2'b00,
    NVSC_OP_WRITE = 2'b01,
    NVSC_OP_STORE = 2'b10,
    NVSC_OP_RECALL = 2'b11
  } nvsc_op_t;
endpackage

/* File: hw/nvsc_seq_rom.sv */
/*
 registered lookup of the six-step nonvolatile address sequence.
 assumes index below six; the last entry depends on store or recall.
*/
`timescale 1ns/100ps
module nvsc_seq_rom
(
  input wire logic clk_sys,
  input wire logic [2:0] idx,
  input wire logic is_recall,
  output logic [12:0] addr
);
  logic [12:0] addr_nxt;
  always_comb
  begin
    unique case (idx)
      3'h0: addr_nxt = nvsc_pkg::SEQ_A0;
      3'h1: addr_nxt = nvsc_pkg::SEQ_A1;
      3'h2: addr_nxt = nvsc_pkg::SEQ_A2;
      3'h3: addr_nxt = nvsc_pkg::SEQ_A3;
      3'h4: addr_nxt = nvsc_pkg::SEQ_A4;
      3'h5: addr_nxt = is_recall ? nvsc_pkg::SEQ_RECALL
                                 : nvsc_pkg::SEQ_STORE;
      default: addr_nxt = nvsc_pkg::SEQ_A0;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    addr <= addr_nxt;
  end
endmodule // nvsc_seq_rom
